// *** vfp_core.sv ***
// Draw command interpreter: instance and vertex loops, vertex entry build
// Operation
// - Codes 2,3,4 write zero, 1.0f, 1
// - Codes 5,6 write vertex, instance ident
// - Destination offset counts 32-bit words
// - Entry zero-padded to 256-bit boundary
// - Accept only the draw command header
// - Bit 9 makes count an address
// - Base bias added only to index values
// - At least one instance runs when the vertex count is nonzero
// - Instance ident starts at zero
// - Sequential vertex ident restarts each instance
// - Each instance resets prim ident, first flag
// - Implicit cut at each instance end
// - Instance ident increments per instance
// - Index, cut or emit, then fetch, write
// - Code 0 skips, code 1 stores source
// - Sequential index is start plus loop
// - Indexed: all-ones cuts, else add bias
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/100ps
module vfp_core (
    // Clock and reset
    input  wire logic           pclk,
    input  wire logic           presetn,
    // APB slave
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [7:0]     paddr,
    input  wire logic [31:0]    pwdata,
    output logic [31:0]         prdata,
    output logic                pready,
    output logic                pslverr,
    // Memory read port
    output logic                rd_req_valid,
    output vfp_pkg::vfp_rd_req_t rd_req,
    input  wire logic           rd_ack,
    input  wire logic           rd_oob,
    input  wire logic [127:0]   rd_data,
    // Vertex output
    output logic                vtx_valid,
    input  wire logic           vtx_ready,
    output vfp_pkg::vfp_vtx_t   vtx,
    output logic [31:0]         inst_data_base
);
    import vfp_pkg::*;

    typedef enum logic [8:0] {
        S_IDLE     = 9'b0_0000_0001,
        S_CNT_WAIT = 9'b0_0000_0010,
        S_INST     = 9'b0_0000_0100,
        S_IDX_GEN  = 9'b0_0000_1000,
        S_IDX_WAIT = 9'b0_0001_0000,
        S_FLUSH    = 9'b0_0010_0000,
        S_SRC_WAIT = 9'b0_0100_0000,
        S_CUT      = 9'b0_1000_0000,
        S_INST_END = 9'b1_0000_0000
    } vfp_state_t;

    vfp_state_t   state_reg;
    logic [31:0]  hdr_reg;
    logic [31:0]  param_reg [N_PARAM];
    logic [2:0]   word_cnt_reg;
    logic         go_reg;
    logic         err_reg;
    logic [31:0]  elem_reg;
    logic [31:0]  prdata_reg;
    logic [31:0]  count_reg;
    logic [31:0]  loop_reg;
    logic [31:0]  inst_reg;
    logic [31:0]  inst_iter_reg;
    logic [31:0]  vid_reg;
    logic [31:0]  vsi_reg;
    logic [31:0]  prim_ident_reg;
    logic         prim_first_reg;
    vfp_rd_req_t  rd_req_reg;
    vfp_vtx_t     buf_reg;
    logic         buf_valid_reg;

    // APB decode
    wire logic        acc      = psel & penable;
    wire logic        hit_cmd  = (paddr == REG_CMD);
    wire logic        hit_elem = (paddr == REG_ELEM);
    wire logic        addr_ok  = hit_cmd | hit_elem | (paddr == REG_STATUS) |
                                 (paddr == REG_INST) | (paddr == REG_COUNT);
    wire logic        busy     = (state_reg != S_IDLE) | go_reg;
    wire logic        wr_cmd   = acc & pwrite & hit_cmd & ~busy;
    wire logic        wr_elem  = acc & pwrite & hit_elem;
    assign pready  = 1'b1;
    assign pslverr = acc & ~addr_ok;
    assign prdata  = prdata_reg;

    // Header recognition
    wire logic hdr_ok = (pwdata[HDR_TYPE_HI -: 3] == CMD_TYPE_VAL) &
                        (pwdata[HDR_SUB_HI -: 2] == CMD_SUB_VAL) &
                        (pwdata[HDR_OPC_HI -: 3] == CMD_OPC_VAL) &
                        (pwdata[HDR_SUBOPC_HI -: 8] == CMD_SUBOPC_VAL);

    // Command fields
    wire logic        random_mode = hdr_reg[HDR_RANDOM];
    wire logic        indirect    = hdr_reg[HDR_INDIRECT];
    wire logic [31:0] start_loc   = param_reg[P_START];
    wire logic [31:0] bias        = param_reg[P_BIAS];
    wire logic [31:0] inst_cnt    = param_reg[P_INSTCNT];
    wire logic [31:0] loop_inc    = loop_reg + 32'h0000_0001;
    wire logic        loop_last   = (loop_inc == count_reg);
    wire logic [31:0] iter_inc    = inst_iter_reg + 32'h0000_0001;
    wire logic        inst_last   = (iter_inc >= inst_cnt);
    wire logic        out_free    = ~buf_valid_reg | vtx_ready;
    wire logic [127:0] rd_val     = rd_oob ? 128'h0 : rd_data;
    wire logic [31:0] idx_val     = rd_val[31:0];
    assign inst_data_base = param_reg[P_STARTINST];

    // Read rdata into a flop during the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            case (paddr)
                REG_CMD:    prdata_reg <= hdr_reg;
                REG_STATUS: prdata_reg <= {30'h0, err_reg, busy};
                REG_ELEM:   prdata_reg <= elem_reg;
                REG_INST:   prdata_reg <= inst_reg;
                REG_COUNT:  prdata_reg <= count_reg;
                default:    prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // Element control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            elem_reg <= ELEM_RESET;
        end else if (wr_elem) begin
            elem_reg <= pwdata;
        end
    end

    // Command word capture: header, then five parameter words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hdr_reg      <= 32'h0000_0000;
            word_cnt_reg <= 3'h0;
            go_reg       <= 1'b0;
            err_reg      <= 1'b0;
            for (int i = 0; i < N_PARAM; i++) begin
                param_reg[i] <= 32'h0000_0000;
            end
        end else begin
            go_reg <= 1'b0;
            if (wr_cmd) begin
                if (word_cnt_reg == 3'h0) begin
                    err_reg <= ~hdr_ok;
                    if (hdr_ok) begin
                        hdr_reg      <= pwdata;
                        word_cnt_reg <= 3'h1;
                    end
                end else begin
                    param_reg[word_cnt_reg - 3'h1] <= pwdata;
                    word_cnt_reg <= (word_cnt_reg == PARAM_LAST) ? 3'h0
                                    : word_cnt_reg + 3'h1;
                    go_reg       <= (word_cnt_reg == PARAM_LAST);
                end
            end
        end
    end

    // Per-component selection
    logic [N_COMP-1:0] comp_en;
    logic [31:0]       comp_val [N_COMP];
    wire logic [2:0]   dst_off = elem_reg[ELEM_OFF_LO +: 3];
    for (genvar c = 0; c < N_COMP; c++) begin : g_comp
        vfp_comp_sel u_sel (
            .ctrl    (vfp_comp_t'(elem_reg[3*c +: 3])),
            .src     (rd_val[32*c +: 32]),
            .vid     (vid_reg),
            .iid     (inst_reg),
            .wr_en   (comp_en[c]),
            .wr_data (comp_val[c])
        );
    end

    // Assemble the entry; unwritten words stay zero up to 256 bits
    logic [255:0] entry_next;
    always_comb begin
        entry_next = 256'h0;
        for (int d = 0; d < N_DWORDS; d++) begin
            for (int c = 0; c < N_COMP; c++) begin
                if (comp_en[c] && (3'(dst_off + 3'(c)) == 3'(d))) begin
                    entry_next[32*d +: 32] = comp_val[c];
                end
            end
        end
    end

    // Read port and vertex output
    assign rd_req_valid = (state_reg == S_CNT_WAIT) | (state_reg == S_IDX_WAIT) |
                          (state_reg == S_SRC_WAIT);
    assign rd_req       = rd_req_reg;
    assign vtx_valid    = buf_valid_reg & ((state_reg == S_FLUSH) |
                          (state_reg == S_CUT) | (state_reg == S_INST_END));
    always_comb begin
        vtx                = buf_reg;
        vtx.prim_last_flag = (state_reg != S_FLUSH);
    end

    // Loop sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg      <= S_IDLE;
            count_reg      <= 32'h0000_0000;
            loop_reg       <= 32'h0000_0000;
            inst_reg       <= 32'h0000_0000;
            inst_iter_reg  <= 32'h0000_0000;
            vid_reg        <= 32'h0000_0000;
            vsi_reg        <= 32'h0000_0000;
            prim_ident_reg <= 32'h0000_0000;
            prim_first_reg <= 1'b0;
            rd_req_reg     <= '{kind: RD_COUNT, addr: 32'h0000_0000};
            buf_reg        <= '0;
            buf_valid_reg  <= 1'b0;
        end else begin
            case (state_reg)
                S_IDLE: if (go_reg) begin
                    inst_reg      <= 32'h0000_0000;
                    inst_iter_reg <= 32'h0000_0000;
                    count_reg     <= param_reg[P_VCOUNT];
                    rd_req_reg    <= '{kind: RD_COUNT,
                                       addr: param_reg[P_VCOUNT] & DWORD_MASK};
                    if (indirect) begin
                        state_reg <= S_CNT_WAIT;
                    end else if (param_reg[P_VCOUNT] != 32'h0000_0000) begin
                        state_reg <= S_INST;
                    end
                end
                S_CNT_WAIT: if (rd_ack) begin
                    count_reg <= idx_val;
                    state_reg <= (idx_val == 32'h0000_0000) ? S_IDLE : S_INST;
                end
                S_INST: begin
                    loop_reg       <= 32'h0000_0000;
                    prim_ident_reg <= 32'h0000_0000;
                    prim_first_reg <= 1'b1;
                    state_reg      <= (count_reg == 32'h0000_0000) ? S_IDLE
                                      : S_IDX_GEN;
                end
                S_IDX_GEN: begin
                    if (random_mode) begin
                        rd_req_reg <= '{kind: RD_INDEX,
                                        addr: start_loc + loop_reg};
                        state_reg  <= S_IDX_WAIT;
                    end else begin
                        vid_reg   <= loop_reg;
                        vsi_reg   <= start_loc + loop_reg;
                        state_reg <= S_FLUSH;
                    end
                end
                S_IDX_WAIT: if (rd_ack) begin
                    vid_reg   <= idx_val;
                    vsi_reg   <= idx_val + bias;
                    state_reg <= (idx_val == ALL_ONES) ? S_CUT : S_FLUSH;
                end
                S_FLUSH: if (out_free) begin
                    buf_valid_reg <= 1'b0;
                    rd_req_reg    <= '{kind: RD_SOURCE, addr: vsi_reg};
                    state_reg     <= S_SRC_WAIT;
                end
                S_SRC_WAIT: if (rd_ack) begin
                    buf_reg <= '{prim_type:       hdr_reg[HDR_TOPO_HI -: 5],
                                 prim_ident:      prim_ident_reg,
                                 prim_first_flag: prim_first_reg,
                                 prim_last_flag:  1'b0,
                                 vertex_ident:    vid_reg,
                                 instance_ident:  inst_reg,
                                 entry:           entry_next};
                    buf_valid_reg  <= 1'b1;
                    prim_first_reg <= 1'b0;
                    loop_reg       <= loop_inc;
                    state_reg      <= loop_last ? S_INST_END : S_IDX_GEN;
                end
                S_CUT: if (out_free) begin
                    buf_valid_reg  <= 1'b0;
                    prim_first_reg <= 1'b1;
                    if (buf_valid_reg) begin
                        prim_ident_reg <= prim_ident_reg + 32'h0000_0001;
                    end
                    loop_reg  <= loop_inc;
                    state_reg <= loop_last ? S_INST_END : S_IDX_GEN;
                end
                S_INST_END: if (out_free) begin
                    buf_valid_reg <= 1'b0;
                    inst_reg      <= inst_reg + 32'h0000_0001;
                    inst_iter_reg <= iter_inc;
                    state_reg     <= inst_last ? S_IDLE : S_INST;
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end
endmodule

// *** vfp_pkg.sv ***
// Package: constants, codes and carrier types for the vertex fetch front end
package vfp_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_ELEM   = 8'h08;
    localparam logic [7:0] REG_INST   = 8'h0C;
    localparam logic [7:0] REG_COUNT  = 8'h10;
    // Command header fields
    localparam int HDR_TYPE_HI   = 31;
    localparam int HDR_SUB_HI    = 28;
    localparam int HDR_OPC_HI    = 26;
    localparam int HDR_SUBOPC_HI = 23;
    localparam int HDR_RANDOM    = 15;
    localparam int HDR_TOPO_HI   = 14;
    localparam int HDR_INDIRECT  = 9;
    localparam logic [2:0] CMD_TYPE_VAL   = 3'h3;
    localparam logic [1:0] CMD_SUB_VAL    = 2'h3;
    localparam logic [2:0] CMD_OPC_VAL    = 3'h3;
    localparam logic [7:0] CMD_SUBOPC_VAL = 8'h00;
    // Parameter words following the header
    localparam int            N_PARAM     = 5;
    localparam logic [2:0]    PARAM_LAST  = 3'h5;
    localparam int            P_VCOUNT    = 0;
    localparam int            P_START     = 1;
    localparam int            P_INSTCNT   = 2;
    localparam int            P_STARTINST = 3;
    localparam int            P_BIAS      = 4;
    // Status and element control fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_ERR_BIT  = 1;
    localparam int ELEM_OFF_LO = 16;
    localparam logic [31:0] ELEM_RESET = 32'h0000_0249;
    // Constant component values, cut index, count address mask and entry sizes
    localparam logic [31:0] FLOAT_ONE  = 32'h3F80_0000;
    localparam logic [31:0] INT_ONE    = 32'h0000_0001;
    localparam logic [31:0] ALL_ONES   = 32'hFFFF_FFFF;
    localparam logic [31:0] DWORD_MASK = 32'hFFFF_FFFC;
    localparam int N_COMP   = 4;
    localparam int N_DWORDS = 8;

    typedef enum logic [2:0] {
        comp_skip                 = 3'h0,
        comp_write_source         = 3'h1,
        comp_write_zero           = 3'h2,
        comp_write_float_one      = 3'h3,
        comp_write_int_one        = 3'h4,
        comp_write_vertex_ident   = 3'h5,
        comp_write_instance_ident = 3'h6
    } vfp_comp_t;

    typedef enum logic [1:0] {
        RD_COUNT  = 2'h0,
        RD_INDEX  = 2'h1,
        RD_SOURCE = 2'h2
    } vfp_rd_kind_t;

    typedef struct packed {
        vfp_rd_kind_t kind;
        logic [31:0]  addr;
    } vfp_rd_req_t;

    typedef struct packed {
        logic [4:0]   prim_type;
        logic [31:0]  prim_ident;
        logic         prim_first_flag;
        logic         prim_last_flag;
        logic [31:0]  vertex_ident;
        logic [31:0]  instance_ident;
        logic [255:0] entry;
    } vfp_vtx_t;
endpackage

// *** vfp_comp_sel.sv ***
// One destination component: picks the value its control code asks for
`timescale 1ns/100ps
module vfp_comp_sel (
    // Control and sources
    input  vfp_pkg::vfp_comp_t ctrl,
    input  wire logic [31:0]   src,
    input  wire logic [31:0]   vid,
    input  wire logic [31:0]   iid,
    // Result
    output logic               wr_en,
    output logic [31:0]        wr_data
);
    import vfp_pkg::*;

    // Decode the control code into a write strobe and value
    always_comb begin
        wr_en   = 1'b1;
        wr_data = 32'h0000_0000;
        case (ctrl)
            comp_skip:                 wr_en = 1'b0;
            comp_write_source:         wr_data = src;
            comp_write_zero:           wr_data = 32'h0000_0000;
            comp_write_float_one:      wr_data = FLOAT_ONE;
            comp_write_int_one:        wr_data = INT_ONE;
            comp_write_vertex_ident:   wr_data = vid;
            comp_write_instance_ident: wr_data = iid;
            default:                   wr_en = 1'b0;
        endcase
    end
endmodule

// *** vfp_core_asserts.sv ***
// Checker: port-level properties of the vertex fetch front end
`timescale 1ns/100ps
module vfp_core_asserts (
    // Clock, reset and APB
    input wire logic           pclk,
    input wire logic           presetn,
    input wire logic           psel,
    input wire logic           penable,
    input wire logic [7:0]     paddr,
    input wire logic           pready,
    input wire logic           pslverr,
    // Read port
    input wire logic           rd_req_valid,
    input vfp_pkg::vfp_rd_req_t rd_req,
    input wire logic           rd_ack,
    // Vertex output
    input wire logic           vtx_valid,
    input wire logic           vtx_ready,
    input vfp_pkg::vfp_vtx_t   vtx
);
    import vfp_pkg::*;
    logic [31:0] prev_iid_reg;
    logic [31:0] prev_pid_reg;
    logic        prev_last_reg;
    logic        unmapped;
    // Decode of addresses outside the register map
    assign unmapped = !(paddr inside {REG_CMD, REG_STATUS, REG_ELEM, REG_INST, REG_COUNT});
    // Fields of the last accepted vertex; a fresh start expects a first vertex
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_iid_reg  <= 32'h0;
            prev_pid_reg  <= 32'h0;
            prev_last_reg <= 1'b1;
        end else if (vtx_valid && vtx_ready) begin
            prev_iid_reg  <= vtx.instance_ident;
            prev_pid_reg  <= vtx.prim_ident;
            prev_last_reg <= vtx.prim_last_flag;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_rd_wait; rd_req_valid && !rd_ack; endsequence
    sequence s_vtx_stall; vtx_valid && !vtx_ready; endsequence
    property p_rd_hold; s_rd_wait |=> rd_req_valid && $stable(rd_req); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read request moved");
    property p_rd_done; rd_req_valid && rd_ack |=> !rd_req_valid; endproperty
    a_rd_done: assert property (p_rd_done) else $error("read not closed");
    property p_cnt_align;
        rd_req_valid && rd_req.kind == RD_COUNT |-> rd_req.addr[1:0] == 2'h0;
    endproperty
    a_cnt_align: assert property (p_cnt_align) else $error("count address unaligned");
    property p_vtx_hold; s_vtx_stall |=> vtx_valid && $stable(vtx); endproperty
    a_vtx_hold: assert property (p_vtx_hold) else $error("vertex moved");
    property p_first_flag; vtx_valid |-> vtx.prim_first_flag == prev_last_reg; endproperty
    a_first_flag: assert property (p_first_flag) else $error("first flag wrong");
    property p_same_prim;
        vtx_valid && !vtx.prim_first_flag |->
            vtx.instance_ident == prev_iid_reg && vtx.prim_ident == prev_pid_reg;
    endproperty
    a_same_prim: assert property (p_same_prim) else $error("ident changed in prim");
    property p_inst_start;
        vtx_valid && vtx.instance_ident != prev_iid_reg |->
            vtx.prim_ident == 32'h0 && vtx.prim_first_flag;
    endproperty
    a_inst_start: assert property (p_inst_start) else $error("instance start bad");
    property p_apb; psel && penable |-> pready && pslverr == unmapped; endproperty
    a_apb: assert property (p_apb) else $error("apb answer wrong");
endmodule
bind vfp_core vfp_core_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .rd_req_valid(rd_req_valid), .rd_req(rd_req), .rd_ack(rd_ack),
    .vtx_valid(vtx_valid), .vtx_ready(vtx_ready), .vtx(vtx));

// *** vfp_mem_model.sv ***
// Memory model: answers count, index and source reads of the fetch unit
`timescale 1ns/100ps
module vfp_mem_model (
    // Clock and reset
    input  wire logic            pclk,
    input  wire logic            presetn,
    // Read port
    input  wire logic            rd_req_valid,
    input  vfp_pkg::vfp_rd_req_t rd_req,
    output logic                 rd_ack,
    output logic                 rd_oob,
    output logic [127:0]         rd_data,
    // Answer delay in cycles
    input  wire logic [3:0]      wait_cyc
);
    import vfp_pkg::*;
    localparam logic [31:0] LIMIT = 32'h0000_0040;
    logic [31:0] idx_mem [64];
    logic [31:0] cnt_val;
    logic [3:0]  wait_reg;
    logic [31:0] noise_reg;
    // Converted source element held at a structure index
    function automatic logic [127:0] src_of(input logic [31:0] a);
        return {a + 32'hC000_0000, a + 32'hB000_0000, a + 32'hA000_0000, a + 32'h9000_0000};
    endfunction
    // One read at a time; data outside an answer is noise, never the last value
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ack    <= 1'b0;
            rd_oob    <= 1'b0;
            rd_data   <= '0;
            wait_reg  <= 4'h0;
            noise_reg <= 32'h0;
        end else begin
            noise_reg <= noise_reg + 32'h3C5A_1E0F;
            rd_ack    <= 1'b0;
            rd_oob    <= 1'b0;
            rd_data   <= {4{~noise_reg}};
            if (rd_req_valid && !rd_ack && wait_reg < wait_cyc) begin
                wait_reg <= wait_reg + 4'h1;
            end else if (rd_req_valid && !rd_ack) begin
                wait_reg <= 4'h0;
                rd_ack   <= 1'b1;
                rd_oob   <= rd_req.addr >= LIMIT;
                if (rd_req.addr < LIMIT) begin
                    case (rd_req.kind)
                        RD_COUNT: rd_data[31:0] <= cnt_val;
                        RD_INDEX: rd_data[31:0] <= idx_mem[rd_req.addr[5:0]];
                        default:  rd_data <= src_of(rd_req.addr);
                    endcase
                end
            end
        end
    end
endmodule

// *** vfp_core_tb.sv ***
// Testbench: APB-driven draw commands checked against expected vertices
`timescale 1ns/100ps
`define CHK(name, exp, got) begin num_checks++; if ((got) !== (exp)) begin err_count++; \
    $display("MISMATCH %s exp=%0h got=%0h", name, exp, got); end end
module vfp_core_tb;
    import vfp_pkg::*;
    logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
    logic [7:0]    paddr;
    logic [31:0]   pwdata, prdata, rdv, inst_data_base;
    logic          rd_req_valid, rd_ack, rd_oob, vtx_valid, vtx_ready;
    vfp_rd_req_t   rd_req;
    logic [127:0]  rd_data;
    vfp_vtx_t      vtx;
    logic [3:0]    wait_cyc;
    logic [1:0]    cyc;
    int            err_count, num_checks;
    vfp_vtx_t      got[$];
    vfp_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rd_req_valid(rd_req_valid), .rd_req(rd_req), .rd_ack(rd_ack),
        .rd_oob(rd_oob), .rd_data(rd_data), .vtx_valid(vtx_valid), .vtx_ready(vtx_ready),
        .vtx(vtx), .inst_data_base(inst_data_base));
    vfp_mem_model u_mem (.pclk(pclk), .presetn(presetn), .rd_req_valid(rd_req_valid),
        .rd_req(rd_req), .rd_ack(rd_ack), .rd_oob(rd_oob), .rd_data(rd_data),
        .wait_cyc(wait_cyc));
    // Clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Vertex sink stalls two cycles in four
    always @(posedge pclk) begin
        cyc <= cyc + 2'h1;
        vtx_ready <= ~cyc[1];
        if (vtx_valid && vtx_ready) got.push_back(vtx);
    end
    // One APB transfer, then one idle cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdv = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Send a draw command, wait until idle, then read the resolved count
    task automatic run(input logic [31:0] h, c, s, n, si, b);
        logic [31:0] w[6];
        w = '{h, c, s, n, si, b};
        got.delete();
        foreach (w[i]) apb(1'b1, REG_CMD, w[i]);
        repeat (2) @(posedge pclk);
        for (int t = 0; t < 300; t++) begin
            apb(1'b0, REG_STATUS, 32'h0);
            if (rdv[0] === 1'b0) break;
        end
        `CHK("status", 2'b00, rdv[1:0])
        apb(1'b0, REG_COUNT, 32'h0);
    endtask
    // Expected entry: four components placed from the dword offset, rest zero
    function automatic logic [255:0] ent(input logic [31:0] el, input logic [127:0] s,
                                         input logic [31:0] vid, iid);
        logic [255:0] e;
        logic [2:0]   d;
        e = '0;
        for (int c = 0; c < 4; c++) begin
            d = el[18:16] + c[2:0];
            case (el[3*c +: 3])
                3'h1: e[32*d +: 32] = s[32*c +: 32];
                3'h3: e[32*d +: 32] = FLOAT_ONE;
                3'h4: e[32*d +: 32] = INT_ONE;
                3'h5: e[32*d +: 32] = vid;
                3'h6: e[32*d +: 32] = iid;
                default: e[32*d +: 32] = e[32*d +: 32];
            endcase
        end
        return e;
    endfunction
    // Compare one accepted vertex
    task automatic chk_v(input int k, input logic [31:0] vid, iid, pid,
                         input logic fst, lst, input logic [255:0] e);
        `CHK("vertex_ident", vid, got[k].vertex_ident)
        `CHK("instance_ident", iid, got[k].instance_ident)
        `CHK("prim_ident", pid, got[k].prim_ident)
        `CHK("flags", {fst, lst}, {got[k].prim_first_flag, got[k].prim_last_flag})
        `CHK("prim_type", 5'h05, got[k].prim_type)
        `CHK("entry", e, got[k].entry)
    endtask
    task automatic close_out();
        $display("Checks made: %0d, mismatches: %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        #200000;
        err_count++;
        close_out();
    end
    // Main sequence
    initial begin
        logic [31:0] v;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        wait_cyc = 4'h0;
        cyc = 2'h0;
        vtx_ready = 1'b0;
        err_count = 0;
        num_checks = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Bad header and unmapped address
        apb(1'b1, REG_CMD, 32'h7B01_1404);
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK("status", 2'b10, rdv[1:0])
        apb(1'b0, 8'h14, 32'h0);
        `CHK("unmapped", 33'h1_0000_0000, {perr, rdv})
        // Sequential: three vertices, two instances, bias ignored
        apb(1'b1, REG_ELEM, 32'h0004_07A9);
        run(32'h7B00_1404, 32'h3, 32'h5, 32'h2, 32'h9, 32'h64);
        `CHK("count", 32'h3, rdv)
        `CHK("inst_data_base", 32'h9, inst_data_base)
        `CHK("vertices", 6, got.size())
        for (int i = 0; i < 6; i++) begin
            v = i % 3;
            chk_v(i, v, i / 3, 0, v == 0, v == 2,
                  ent(32'h0004_07A9, u_mem.src_of(v + 5), v, i / 3));
        end
        // Indexed: cut, indirect count, negative bias, out-of-range reads
        u_mem.cnt_val = 32'h4;
        u_mem.idx_mem[61] = 32'h7;
        u_mem.idx_mem[62] = ALL_ONES;
        u_mem.idx_mem[63] = 32'h1;
        wait_cyc <= 4'h3;
        apb(1'b1, REG_ELEM, 32'h0000_0062);
        run(32'h7B00_9604, 32'h13, 32'h3D, 32'h0, 32'h7, 32'hFFFF_FFFE);
        `CHK("count", 32'h4, rdv)
        `CHK("vertices", 3, got.size())
        chk_v(0, 32'h7, 0, 0, 1, 1, ent(32'h62, u_mem.src_of(32'h5), 7, 0));
        chk_v(1, 32'h1, 0, 1, 1, 0, ent(32'h62, '0, 1, 0));
        chk_v(2, 32'h0, 0, 1, 0, 1, ent(32'h62, '0, 0, 0));
        // Zero vertex count emits nothing
        run(32'h7B00_1404, 32'h0, 32'h5, 32'h2, 32'h0, 32'h0);
        `CHK("count", 32'h0, rdv)
        `CHK("vertices", 0, got.size())
        close_out();
    end
endmodule
